// file: rtl/eesw_top.sv
/*
 * Two-wire slave front end of a byte-wide nonvolatile array with page
 * write, write protection, self-timed programming and an APB window.
 * Assumes an external pull-up on the data line, pull-downs on the select
 * pins, and a serial clock far slower than pclk.
 */
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module eesw_top
   import eesw_pkg::*;
#(
   parameter int PROG_LEN = PROG_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic device_select_bit0_pin,
   input wire logic device_select_bit1_pin,
   input wire logic device_select_bit2_pin,
   input wire logic write_protect_pin,
   output logic program_busy
);
   // ----------------------------------------------------------------------
   // pin sampling and bus conditions
   // ----------------------------------------------------------------------
   logic [SYNC_W-1:0] syn;
   logic scl_s, sda_s, scl_d, sda_d, wp_s;
   logic [2:0] ds;
   logic scl_rise, scl_fall, start_det, stop_det;

   eesw_sync #(.WIDTH(SYNC_W)) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d_in({write_protect_pin, device_select_bit2_pin, device_select_bit1_pin,
             device_select_bit0_pin, sda_in, scl}),
      .d_out(syn)
   );

   assign scl_s = syn[0];
   assign sda_s = syn[1];
   // open select pins
   // pad pull-downs make an open select pin read as zero here
   assign ds = syn[4:2];
   assign wp_s = syn[5];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_d <= 1'b0;
         sda_d <= 1'b0;
      end else begin
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

   // ----------------------------------------------------------------------
   // byte decode
   // ----------------------------------------------------------------------
   eesw_state_t state;
   logic [2:0] bit_cnt;
   logic [7:0] shreg, addr_hi, rx_byte;
   logic [1:0] rx_index;
   logic read_mode, ack_want, mack_seen, mack_ok;
   logic [ADDR_W-1:0] addr, addr_top, prot_top, full_addr;
   logic size_64k, busy, abort, data_seen;
   logic [PROG_CNT_W-1:0] prog_cnt;
   logic [7:0] mem [MEM_DEPTH];
   logic [7:0] pbuf [PAGE_SIZE];
   logic [PAGE_SIZE-1:0] vld;
   logic addr_match, prot_now, ack_next, byte_end, tx_load, prog_done;

   assign rx_byte = {shreg[6:0], sda_s};
   assign byte_end = scl_rise && state == ST_RECV && bit_cnt == 3'h7;
   assign addr_top = size_64k ? WRAP_64K : WRAP_32K;
   assign prot_top = size_64k ? PROT_TOP_64K : PROT_TOP_32K;
   assign full_addr = {addr_hi[ADDR_W-9:0], rx_byte} & addr_top;
   assign addr_match = rx_byte[7:4] == SLAVE_TYPE_ID && rx_byte[3:1] == ds;
   assign prot_now = wp_s && addr <= prot_top;

   always_comb begin
      unique case (rx_index)
         PH_DEV: ack_next = addr_match;
         PH_AHI: ack_next = 1'b1;
         PH_ALO: ack_next = 1'b1;
         PH_DATA: ack_next = !(abort || (!data_seen && prot_now));
      endcase
   end

   assign tx_load = scl_fall && ((state == ST_ACK && read_mode)
                    || (state == ST_MACK && mack_seen && mack_ok));
   assign prog_done = busy && prog_cnt == PROG_CNT_W'(PROG_LEN - 1);

   // ----------------------------------------------------------------------
   // serial state machine
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         bit_cnt <= 3'h0;
         shreg <= 8'h00;
         rx_index <= PH_DEV;
         read_mode <= 1'b0;
         ack_want <= 1'b0;
         mack_seen <= 1'b0;
         mack_ok <= 1'b0;
         sda_oe <= 1'b0;
      end else if (busy) begin
         state <= ST_IDLE;
         sda_oe <= 1'b0;
      end else if (start_det) begin
         state <= ST_RECV;
         bit_cnt <= 3'h0;
         rx_index <= PH_DEV;
         sda_oe <= 1'b0;
      end else if (stop_det) begin
         state <= ST_IDLE;
         sda_oe <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: ;
            ST_RECV: begin
               if (scl_rise) begin
                  shreg <= rx_byte;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     ack_want <= ack_next;
                     state <= ST_ACKW;
                     if (rx_index == PH_DEV) begin
                        read_mode <= rx_byte[0];
                     end
                     if (rx_index != PH_DATA) begin
                        rx_index <= rx_index + 2'h1;
                     end
                  end
               end
            end
            ST_ACKW: begin
               if (scl_fall) begin
                  sda_oe <= ack_want;
                  state <= ack_want ? ST_ACK : ST_WAIT;
               end
            end
            ST_ACK: begin
               if (tx_load) begin
                  shreg <= mem[addr];
                  sda_oe <= ~mem[addr][7];
                  bit_cnt <= 3'h0;
                  state <= ST_SEND;
               end else if (scl_fall) begin
                  sda_oe <= 1'b0;
                  bit_cnt <= 3'h0;
                  state <= ST_RECV;
               end
            end
            ST_SEND: begin
               if (scl_fall) begin
                  if (bit_cnt == 3'h7) begin
                     sda_oe <= 1'b0;
                     mack_seen <= 1'b0;
                     state <= ST_MACK;
                  end else begin
                     shreg <= {shreg[6:0], 1'b0};
                     sda_oe <= ~shreg[6];
                     bit_cnt <= bit_cnt + 3'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  mack_seen <= 1'b1;
                  mack_ok <= ~sda_s;
               end else if (tx_load) begin
                  shreg <= mem[addr];
                  sda_oe <= ~mem[addr][7];
                  bit_cnt <= 3'h0;
                  state <= ST_SEND;
               end else if (scl_fall && mack_seen) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: ;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // address counter and write session
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr <= '0;
         addr_hi <= 8'h00;
      end else if (byte_end && rx_index == PH_AHI) begin
         addr_hi <= rx_byte;
      end else if (byte_end && rx_index == PH_ALO) begin
         addr <= full_addr;
      end else if (byte_end && rx_index == PH_DATA && ack_next) begin
         addr <= {addr[ADDR_W-1:PAGE_BITS], addr[PAGE_BITS-1:0] + 5'h01};
      end else if (tx_load) begin
         addr <= (addr == addr_top) ? '0 : addr + 13'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort <= 1'b0;
         data_seen <= 1'b0;
      end else if (byte_end && rx_index == PH_ALO) begin
         abort <= 1'b0;
         data_seen <= 1'b0;
      end else if (byte_end && rx_index == PH_DATA) begin
         data_seen <= 1'b1;
         // set has priority: nothing else clears in this cycle
         if (!ack_next) begin
            abort <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // page buffer
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vld <= '0;
      end else if (prog_done || (start_det && !busy)) begin
         // a repeated start abandons an unfinished page
         vld <= '0;
      end else if (byte_end && rx_index == PH_ALO) begin
         vld <= '0;
      end else if (byte_end && rx_index == PH_DATA && ack_next) begin
         vld[addr[PAGE_BITS-1:0]] <= 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (byte_end && rx_index == PH_DATA && ack_next) begin
         pbuf[addr[PAGE_BITS-1:0]] <= rx_byte;
      end
   end

   // ----------------------------------------------------------------------
   // self-timed programming
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         prog_cnt <= '0;
      end else if (!busy) begin
         if (stop_det && |vld && !abort) begin
            busy <= 1'b1;
            prog_cnt <= '0;
         end
      end else begin
         prog_cnt <= prog_cnt + 20'h0_0001;
         if (prog_done) begin
            busy <= 1'b0;
         end
      end
   end

   // one entry per cycle keeps the write port single; 32 cycles is far
   // below the programming time, so the whole page lands before programming ends
   always_ff @(posedge pclk) begin
      if (busy && prog_cnt < PROG_CNT_W'(PAGE_SIZE) && vld[prog_cnt[PAGE_BITS-1:0]]) begin
         mem[{addr[ADDR_W-1:PAGE_BITS], prog_cnt[PAGE_BITS-1:0]}] <=
            pbuf[prog_cnt[PAGE_BITS-1:0]];
      end
   end

   assign program_busy = busy;

   // ----------------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------------
   logic [ADDR_W-1:0] mem_index;
   logic [31:0] stat;
   logic apb_access, apb_commit;

   assign apb_access = psel && penable && !pready;
   assign apb_commit = psel && penable && pready && pwrite;

   always_comb begin
      stat = 32'h0000_0000;
      stat[STAT_BUSY_BIT] = busy;
      stat[STAT_ABORT_BIT] = abort;
      stat[STAT_ACTIVE_BIT] = state != ST_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= apb_access;
         pslverr <= 1'b0;
         if (apb_access) begin
            prdata <= 32'h0000_0000;
            unique case (paddr)
               CTRL_OFS: prdata[CTRL_SIZE_BIT] <= size_64k;
               STATUS_OFS: prdata <= stat;
               ADDR_OFS: prdata[ADDR_W-1:0] <= addr;
               MEM_INDEX_OFS: prdata[ADDR_W-1:0] <= mem_index;
               MEM_DATA_OFS: prdata[7:0] <= mem[mem_index];
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         size_64k <= CTRL_SIZE_RST;
         mem_index <= '0;
      end else if (apb_commit && paddr == CTRL_OFS) begin
         size_64k <= pwdata[CTRL_SIZE_BIT];
      end else if (apb_commit && paddr == MEM_INDEX_OFS) begin
         mem_index <= pwdata[ADDR_W-1:0];
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence byte_end_s;
      scl_rise && state == ST_RECV && bit_cnt == 3'h7;
   endsequence

   sequence prot_first_s;
      byte_end_s and (rx_index == PH_DATA && !data_seen && prot_now);
   endsequence

   busy_release_a: assert property (busy |-> !sda_oe && state == ST_IDLE)
      else $error("data line driven while programming");
   prog_bound_a: assert property (busy |-> prog_cnt < PROG_CNT_W'(PROG_LEN))
      else $error("programming exceeds its time");
   start_enter_a: assert property (start_det && !busy |=> state == ST_RECV && bit_cnt == 3'h0)
      else $error("start not taken");
   stop_idle_a: assert property (stop_det && !busy |=> state == ST_IDLE && !sda_oe)
      else $error("stop not taken");
   prog_start_a: assert property ($rose(busy) |-> $past(stop_det))
      else $error("programming began without stop");
   drive_low_a: assert property (sda_oe |-> !sda_out)
      else $error("data line driven high");
   dev_ack_a: assert property ((byte_end_s and (rx_index == PH_DEV && addr_match))
      |=> state == ST_ACKW && ack_want ##[1:40] sda_oe)
      else $error("matching address not acknowledged");
   page_hold_a: assert property (byte_end_s and (rx_index == PH_DATA)
      |=> $stable(addr[ADDR_W-1:PAGE_BITS]))
      else $error("page bits moved during page write");
   protect_nack_a: assert property (prot_first_s |=> abort && !ack_want)
      else $error("protected byte acknowledged");
   read_stop_a: assert property (state == ST_MACK && scl_fall && mack_seen && !mack_ok
      && !busy |=> state == ST_WAIT && !sda_oe)
      else $error("read continued after nack");
endmodule

// file: rtl/eesw_pkg.sv
/*
 * Constants and types shared by the two-wire memory slave front end.
 * Assumes a 100 MHz pclk; the serial lines are sampled on that clock.
 */
// How it works
// - programming ends at most 10 ms after the stop that closed the write
// - while programming, the bus is ignored and the data line stays released
// - master makes clock, start and stop; this block is only a slave
// - data line is open drain: pulled low or released, never driven high
// - unconnected select pins count as zero
// - protect pin high makes bottom quarter read only, else all writable
// - protected write: ack device and address, nack first data, no program
// - data changes only with clock low; changes with clock high are start or stop
// - start is data falling with clock high; nothing happens before a start
// - stop is data rising with clock high; every operation ends with one
// - slave address is 1010, three select pins, then direction bit
// - matching address is acknowledged in the ninth clock, then read or write
// - when selected for write, every received byte is acknowledged except the data bytes of a protected write
// - read: send 8 bits, sample ack; ack sends next, nack waits for stop
// - byte write: address, two address bytes, one data byte, stop starts programming
// - page write takes up to 32 bytes, stepping only the five low address bits
// - extra bytes wrap in the page and overwrite earlier ones
// - programming starts only at stop and writes the buffered page bytes one per cycle
// - address polled during programming gets no ack, afterwards an ack
// - address counter holds last address plus one, wrapping at the page end in writes and at the array top in reads

package eesw_pkg;
   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int PROGRAM_CYCLE_TIME_MS = 10;
   localparam int CLK_FREQ_KHZ = 100_000;
   // longest time: exact product, so no rounding is needed
   localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_MS * CLK_FREQ_KHZ;
   localparam int PROG_CNT_W = 20;

   // ----------------------------------------------------------------------
   // array and serial format
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int PAGE_BITS = 5;
   localparam int PAGE_SIZE = 32;
   localparam int MEM_DEPTH = 8192;
   localparam int SYNC_W = 6;
   localparam logic [3:0] SLAVE_TYPE_ID = 4'ha;
   localparam logic [ADDR_W-1:0] WRAP_64K = 13'h1fff;
   localparam logic [ADDR_W-1:0] WRAP_32K = 13'h0fff;
   localparam logic [ADDR_W-1:0] PROT_TOP_64K = 13'h07ff;
   localparam logic [ADDR_W-1:0] PROT_TOP_32K = 13'h03ff;
   localparam logic [1:0] PH_DEV = 2'h0;
   localparam logic [1:0] PH_AHI = 2'h1;
   localparam logic [1:0] PH_ALO = 2'h2;
   localparam logic [1:0] PH_DATA = 2'h3;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] ADDR_OFS = 8'h08;
   localparam logic [7:0] MEM_INDEX_OFS = 8'h0c;
   localparam logic [7:0] MEM_DATA_OFS = 8'h10;
   localparam int CTRL_SIZE_BIT = 0;
   localparam logic CTRL_SIZE_RST = 1'b1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_ABORT_BIT = 1;
   localparam int STAT_ACTIVE_BIT = 2;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RECV, ST_ACKW, ST_ACK, ST_SEND, ST_MACK, ST_WAIT
   } eesw_state_t;
endpackage

// file: rtl/eesw_sync.sv
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk; outputs reset low.
 */
`timescale 1ns/1ps
module eesw_sync
   import eesw_pkg::*;
#(
   parameter int WIDTH = SYNC_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] d_out
);
   logic [WIDTH-1:0] meta;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               meta[i] <= 1'b0;
               d_out[i] <= 1'b0;
            end else begin
               meta[i] <= d_in[i];
               d_out[i] <= meta[i];
            end
         end
      end
   endgenerate
endmodule

// file: tb/eesw_master.sv
/*
 * Two-wire bus master model: drives the serial clock and data.
 * Assumes a pull-up on the data wire; pclk paces every bit.
 */
`timescale 1ns/1ps
module eesw_master (
   input wire logic pclk,
   input wire logic sda,
   output logic scl,
   output logic sda_oe
);
   // clock stands high between frames
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic start();
      sda_oe <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(3);
      sda_oe <= 1'b1;
      tick(3);
      scl <= 1'b0;
      tick(1);
   endtask
   task automatic stop();
      sda_oe <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(3);
      sda_oe <= 1'b0;
      tick(4);
   endtask
   // data moves one pclk after the clock falls
   task automatic bit_x(input logic b, output logic s);
      sda_oe <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(2);
      s = sda;
      tick(1);
      scl <= 1'b0;
      tick(1);
   endtask
   task automatic put(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_x(d[i], s);
      bit_x(1'b1, s);
      ack = ~s;
   endtask
   task automatic get(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(~ack, s);
   endtask
endmodule

// file: tb/test_eesw_top.sv
/*
 * Self-checking bench for the two-wire memory slave front end.
 * Assumes eesw_master as the far side and a pull-up on the data wire.
 */
`timescale 1ns/1ps
module test_eesw_top;
   import eesw_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, scl, sda, sda_out, sda_oe, m_oe, busy, err, ack;
   logic [2:0] sel = 3'h0;
   logic wp = 1'b0;
   logic [7:0] d;
   int miscompares = 0;
   int n_tests = 0;
   // rows: select pins, address byte, expected ack
   logic [11:0] rows [8] = '{12'h141, 12'h144, 12'hb55, 12'hb50,
      12'hf5d, 12'hf7c, 12'h549, 12'h540};
   always #5 pclk = ~pclk;
   assign sda = (sda_oe | m_oe) ? 1'b0 : 1'b1;
   eesw_top #(.PROG_LEN(200)) u_eesw_top (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
      .device_select_bit0_pin(sel[0]), .device_select_bit1_pin(sel[1]),
      .device_select_bit2_pin(sel[2]), .write_protect_pin(wp),
      .program_busy(busy));
   eesw_master u_eesw_master (.pclk(pclk), .sda(sda), .scl(scl), .sda_oe(m_oe));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // no fixed wait count: only the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic mem(input logic [12:0] a, input logic [7:0] exp);
      apb(1'b1, MEM_INDEX_OFS, {19'h0, a});
      apb(1'b0, MEM_DATA_OFS, 32'h0);
      chk("array byte", rd, {24'h0, exp});
   endtask
   task automatic wr(input logic [15:0] a, input int n, input logic [7:0] b, input logic dk);
      u_eesw_master.start();
      u_eesw_master.put({4'ha, sel, 1'b0}, ack);
      chk("device ack", ack, 1);
      u_eesw_master.put(a[15:8], ack);
      chk("high ack", ack, 1);
      u_eesw_master.put(a[7:0], ack);
      chk("low ack", ack, 1);
      for (int i = 0; i < n; i++) begin
         u_eesw_master.put(8'(b + i), ack);
         chk("data ack", ack, dk);
      end
      u_eesw_master.stop();
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 210) begin
         @(posedge pclk);
         k++;
      end
      chk("program time", busy, 0);
   endtask
   initial begin
      repeat (30000) @(posedge pclk);
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge pclk);
      chk("reset data", sda_out, 0);
      presetn <= 1'b1;
      // scaled settling wait before the first frame
      repeat (20) @(posedge pclk);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("size reset", rd, 1);
      for (int i = 0; i < 8; i++) begin
         sel <= rows[i][11:9];
         repeat (4) @(posedge pclk);
         u_eesw_master.start();
         u_eesw_master.put(rows[i][8:1], ack);
         chk("select ack", ack, rows[i][0]);
         u_eesw_master.stop();
      end
      sel <= 3'h3;
      wp <= 1'b1;
      wr(16'h0810, 2, 8'h5a, 1'b1);
      repeat (5) @(posedge pclk);
      chk("busy", busy, 1);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("status busy", rd[STAT_BUSY_BIT], 1);
      u_eesw_master.start();
      u_eesw_master.put(8'ha6, ack);
      chk("poll busy", ack, 0);
      u_eesw_master.stop();
      wait_idle();
      u_eesw_master.start();
      u_eesw_master.put(8'ha6, ack);
      chk("poll done", ack, 1);
      u_eesw_master.stop();
      mem(13'h0810, 8'h5a);
      wr(16'h07ff, 1, 8'ha5, 1'b0);
      repeat (10) @(posedge pclk);
      chk("no program", busy, 0);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk("abort", rd[STAT_ABORT_BIT], 1);
      wp <= 1'b0;
      // wrap from page offset 30, upper bits ignored
      wr(16'he13e, 34, 8'h40, 1'b1);
      wait_idle();
      mem(13'h013e, 8'h60);
      mem(13'h013f, 8'h61);
      mem(13'h0120, 8'h42);
      mem(13'h013d, 8'h5f);
      wr(16'h0810, 0, 8'h00, 1'b1);
      u_eesw_master.start();
      u_eesw_master.put(8'ha7, ack);
      chk("read ack", ack, 1);
      u_eesw_master.get(1'b1, d);
      chk("read one", d, 8'h5a);
      u_eesw_master.get(1'b0, d);
      chk("read two", d, 8'h5b);
      u_eesw_master.stop();
      apb(1'b0, ADDR_OFS, 32'h0);
      chk("counter", rd, 32'h0000_0812);
      apb(1'b1, CTRL_OFS, 32'h0);
      wp <= 1'b1;
      wr(16'h13ff, 1, 8'h11, 1'b0);
      wr(16'h0400, 1, 8'h77, 1'b1);
      wait_idle();
      mem(13'h0400, 8'h77);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", err, 1);
      finish_test();
   end
endmodule
